// ==== logic/switch_controller.sv ====
// controller end: wishbone registers, frame engine and direct drive pacing
`timescale 1ns/100ps
module switch_controller
  import switch_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_CYC,
  parameter int PWM_MIN   = PWM_MIN_LEVEL_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  switch_link_if.ctrl      link
);
  localparam int DIV_W  = $clog2(SCLK_HALF + 1);
  localparam int HOLD_W = $clog2(PWM_MIN + 1);

  xfer_state_t       state_q;
  logic [DIV_W-1:0]  div_q;
  logic [5:0]        bits_q;
  logic [31:0]       shreg_q, rx_q, tx_q;
  logic [2:0]        len_q;
  logic [3:0]        direct_q;
  logic [1:0]        irq_stat_q, irq_mask_q, ev;
  logic              sclk_q, cs_n_q, mosi_q, miso_s, irq_q;
  logic              req, wr, rd, start, busy, tick;
  logic [1:0]        drive_q;
  logic [HOLD_W-1:0] hold_q [2];
  logic [31:0]       frame_word;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) old_v[8*i +: 8] = new_v[8*i +: 8];
    end
    return old_v;
  endfunction

  // pwm owned outputs are commanded off in every byte of the frame
  function automatic logic [31:0] mask_cmd(input logic [31:0] d, input logic [1:0] mode);
    for (int i = 0; i < MAX_BYTES; i++) begin
      if (mode[0]) d[8*i + FIVE_IDX] = 1'b0;
      if (mode[1]) d[8*i + SIX_IDX]  = 1'b0;
    end
    return d;
  endfunction

  pin_sync #(.W(1), .RESET_VALUE(1'b0)) u_miso (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (link.miso),
    .sync_out (miso_s)
  );

  assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr    = req & wb_we_i;
  assign rd    = req & ~wb_we_i;
  assign start = wr & (wb_adr_i == ADDR_CTRL) & wb_sel_i[0] & wb_dat_i[CTRL_START_BIT];
  assign busy  = (state_q != ST_IDLE);
  assign tick  = (div_q == '0);
  assign ev[IRQ_DONE_BIT]    = (state_q == ST_LAG) & tick;
  assign ev[IRQ_REFUSED_BIT] = start & busy;
  // frame left aligned so the first bit to send sits at bit 31
  assign frame_word = mask_cmd(tx_q, direct_q[DIRECT_MODE_LSB +: 2])
                      << (6'(8) * (6'(MAX_BYTES) - 6'(len_q)));

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_q       <= TX_RESET;
      len_q      <= LEN_RESET;
      direct_q   <= DIRECT_RESET;
      irq_mask_q <= MASK_RESET;
    end else if (wr) begin
      if (wb_adr_i == ADDR_TX) tx_q <= merge(tx_q, wb_dat_i, wb_sel_i);
      if (wb_adr_i == ADDR_LEN && wb_sel_i[0] && wb_dat_i[2:0] != 3'h0
          && wb_dat_i[2:0] <= 3'(MAX_BYTES)) len_q <= wb_dat_i[2:0];
      if (wb_adr_i == ADDR_DIRECT && wb_sel_i[0]) direct_q <= wb_dat_i[3:0];
      if (wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) irq_mask_q <= wb_dat_i[1:0];
    end
  end

  // read clears the status; an event in the same cycle survives
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) irq_stat_q <= '0;
    else if (rd && wb_adr_i == ADDR_IRQ_STAT) irq_stat_q <= ev;
    else irq_stat_q <= irq_stat_q | ev;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      irq_q    <= 1'b0;
    end else begin
      wb_ack_o <= req;
      irq_q    <= |(irq_stat_q & irq_mask_q);
      wb_dat_o <= '0;
      if (rd) begin
        unique case (wb_adr_i)
          ADDR_TX:       wb_dat_o <= tx_q;
          ADDR_RX:       wb_dat_o <= rx_q;
          ADDR_LEN:      wb_dat_o <= {29'h0, len_q};
          ADDR_DIRECT:   wb_dat_o <= {28'h0, direct_q};
          ADDR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat_q};
          ADDR_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask_q};
          ADDR_STATUS:   wb_dat_o <= {31'h0, busy};
          default:       wb_dat_o <= '0;
        endcase
      end
    end
  end

  // clock held low around every select edge; data changes at select fall and then only mid-bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      div_q   <= '0;
      bits_q  <= '0;
      shreg_q <= '0;
      rx_q    <= '0;
      sclk_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      mosi_q  <= 1'b0;
    end else begin
      if (!tick) div_q <= div_q - 1'b1;
      else div_q <= DIV_W'(SCLK_HALF - 1);
      unique case (state_q)
        ST_IDLE: if (start) begin
          shreg_q <= frame_word;
          mosi_q  <= frame_word[31];
          bits_q  <= 6'(8) * 6'(len_q);
          rx_q    <= '0;
          cs_n_q  <= 1'b0;
          div_q   <= DIV_W'(SCLK_HALF - 1);
          state_q <= ST_LEAD;
        end
        ST_LEAD: if (tick) begin
          sclk_q  <= 1'b1;
          state_q <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          sclk_q  <= 1'b0;
          rx_q    <= {rx_q[30:0], miso_s};
          shreg_q <= {shreg_q[30:0], 1'b0};
          bits_q  <= bits_q - 1'b1;
          state_q <= (bits_q == 6'h1) ? ST_LAG : ST_LOW;
        end
        ST_LOW: if (tick) begin
          sclk_q  <= 1'b1;
          mosi_q  <= shreg_q[31];
          state_q <= ST_HIGH;
        end
        ST_LAG: if (tick) begin
          cs_n_q  <= 1'b1;
          state_q <= ST_GAP;
        end
        ST_GAP: if (tick) state_q <= ST_IDLE;
      endcase
    end
  end

  // each direct level lasts at least half the fastest pwm period
  for (genvar g = 0; g < 2; g++) begin : g_direct
    logic want;
    assign want = direct_q[DIRECT_MODE_LSB + g] & direct_q[DIRECT_LEVEL_LSB + g];
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        drive_q[g] <= 1'b0;
        hold_q[g]  <= '0;
      end else if (hold_q[g] != '0) begin
        hold_q[g] <= hold_q[g] - 1'b1;
      end else if (want != drive_q[g]) begin
        drive_q[g] <= want;
        hold_q[g]  <= HOLD_W'(PWM_MIN - 1);
      end
    end
  end

  assign irq_o                  = irq_q;
  assign link.sclk              = sclk_q;
  assign link.cs_n              = cs_n_q;
  assign link.serial_command_in = mosi_q;
  assign link.direct_drive_five = drive_q[0];
  assign link.direct_drive_six  = drive_q[1];
endmodule

// ==== shared/switch_pkg.sv ====
// shared constants, register map and types for the octal switch link
package switch_pkg;
  localparam int NUM_OUTPUTS        = 8;
  localparam int FIVE_IDX           = 4;
  localparam int SIX_IDX            = 5;
  localparam int MAX_BYTES          = 4;
  localparam int CLK_PERIOD_NS      = 25;
  // serial clock half period; a least time, so rounded up
  localparam int SCLK_HALF_NS       = 250;
  localparam int SCLK_HALF_CYC      = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // fastest direct drive toggle: each level lasts half a period of the top rate
  localparam int PWM_MAX_HZ         = 2000;
  localparam int PWM_MIN_LEVEL_NS   = 1000000000 / (2 * PWM_MAX_HZ);
  localparam int PWM_MIN_LEVEL_CYC  =
    (PWM_MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_TX       = 8'h04;
  localparam logic [7:0] ADDR_RX       = 8'h08;
  localparam logic [7:0] ADDR_LEN      = 8'h0c;
  localparam logic [7:0] ADDR_DIRECT   = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam int CTRL_START_BIT     = 0;
  localparam int DIRECT_MODE_LSB    = 0;
  localparam int DIRECT_LEVEL_LSB   = 2;
  localparam int IRQ_DONE_BIT       = 0;
  localparam int IRQ_REFUSED_BIT    = 1;
  localparam int STATUS_BUSY_BIT    = 0;
  localparam logic [2:0]  LEN_RESET    = 3'h1;
  localparam logic [31:0] TX_RESET     = 32'h0000_0000;
  localparam logic [3:0]  DIRECT_RESET = 4'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h0;
  typedef enum {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_LAG, ST_GAP} xfer_state_t;
endpackage

// ==== shared/switch_link_if.sv ====
// serial link and direct drive wires between controller and switch device
`timescale 1ns/100ps
interface switch_link_if;
  logic sclk;
  logic cs_n;
  logic serial_command_in;
  logic status_out;
  logic status_oe;
  logic direct_drive_five;
  logic direct_drive_six;
  logic miso;
  // undriven status line is pulled low
  assign miso = status_oe & status_out;
  modport device (
    input  sclk, cs_n, serial_command_in, direct_drive_five, direct_drive_six,
    output status_out, status_oe
  );
  modport ctrl (
    output sclk, cs_n, serial_command_in, direct_drive_five, direct_drive_six,
    input  miso
  );
endinterface

// ==== logic/pin_sync.sv ====
// two flip-flop synchroniser for pins from another clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int             W           = 1,
  parameter logic [W-1:0]   RESET_VALUE = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== logic/switch_device.sv ====
// octal serial switch: shift path, output latch, fault status and gate drive
// What this block does
// - status pin driven only while select is low
// - any fault reads one, healthy output zero
// - output eight status first, then downward
// - both words move msb first, fifo path
// - drive and detect only when enabled, report regardless
// - latched commands return when enable rises again
// - outputs five, six OR direct drive inputs
// - master holds direct low under serial control
// - master toggles direct inputs no faster than limit
// - held in reset, drivers off, without supply
// - command one turns on, zero off
// - daisy chain passes data through each device
// - select rising edge latches shift register
// - parallel devices each get own select
// - sample command on falling, shift status rising
// - select falling edge loads fault status
// - ignore clock and data while deselected
`timescale 1ns/100ps
module switch_device
  import switch_pkg::*;
#(
  parameter int N = NUM_OUTPUTS
) (
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  switch_link_if.device     link,
  input  wire logic         chip_enable,
  input  wire logic         supply_good,
  input  wire logic [N-1:0] open_load,
  input  wire logic [N-1:0] short_load,
  output logic      [N-1:0] gate_drive,
  output logic      [N-1:0] command_latched
);
  localparam int SYNC_W = 7 + 2 * N;
  // select idles high so the device does not think it is addressed at reset
  localparam logic [SYNC_W-1:0] PINS_RESET = SYNC_W'(2);

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic              sclk_s;
  logic              cs_n_s;
  logic              sdi_s;
  logic              drive5_s;
  logic              drive6_s;
  logic              enable_s;
  logic              supply_s;
  logic [N-1:0]      open_s;
  logic [N-1:0]      short_s;

  logic              sclk_prev_q;
  logic              cs_prev_q;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              cs_fall;
  logic              cs_rise;
  logic              por_ok;

  logic [N-1:0]      fault_now;
  logic [N-1:0]      fault_hold_q;
  logic [N-1:0]      shift_q;
  logic [N-1:0]      cmd_q;
  logic [N-1:0]      direct_mask;
  logic [N-1:0]      gate_q;
  logic              sdo_q;
  logic              sdo_oe_q;

  // level edge of a synchronised pin against its previous sample
  function automatic logic rise_of(input logic now_v, input logic prev_v);
    return now_v & ~prev_v;
  endfunction

  function automatic logic fall_of(input logic now_v, input logic prev_v);
    return ~now_v & prev_v;
  endfunction

  // bit order matches the slices taken below
  assign pins_raw = {short_load,
                     open_load,
                     supply_good,
                     chip_enable,
                     link.direct_drive_six,
                     link.direct_drive_five,
                     link.serial_command_in,
                     link.cs_n,
                     link.sclk};

  pin_sync #(
    .W           (SYNC_W),
    .RESET_VALUE (PINS_RESET)
  ) u_pins (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .async_in (pins_raw),
    .sync_out (pins_s)
  );

  assign sclk_s   = pins_s[0];
  assign cs_n_s   = pins_s[1];
  assign sdi_s    = pins_s[2];
  assign drive5_s = pins_s[3];
  assign drive6_s = pins_s[4];
  assign enable_s = pins_s[5];
  assign supply_s = pins_s[6];
  assign open_s   = pins_s[7 +: N];
  assign short_s  = pins_s[7 + N +: N];

  // the supply monitor acts as a synchronous hold on top of the pin reset
  assign por_ok = supply_s;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // reset to the idle level so no false select edge follows reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_n_s;
    end
  end

  // clock edges only count while selected
  assign sclk_rise = rise_of(sclk_s, sclk_prev_q) & ~cs_n_s;
  assign sclk_fall = fall_of(sclk_s, sclk_prev_q) & ~cs_n_s;
  assign cs_fall   = fall_of(cs_n_s, cs_prev_q);
  assign cs_rise   = rise_of(cs_n_s, cs_prev_q);

  // open and short faults alike read as one
  assign fault_now = (open_s | short_s) & {N{enable_s}};

  // faults stick until loaded for a frame; a new fault in the load cycle wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_hold_q <= '0;
    end else if (!por_ok) begin
      fault_hold_q <= '0;
    end else if (cs_fall) begin
      fault_hold_q <= fault_now;
    end else begin
      fault_hold_q <= fault_hold_q | fault_now;
    end
  end

  // single eight stage path: status out of the top, command into the bottom
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= '0;
    end else if (!por_ok) begin
      shift_q <= '0;
    end else if (cs_fall) begin
      shift_q <= fault_hold_q | fault_now;
    end else if (sclk_fall) begin
      shift_q <= {shift_q[N-2:0], sdi_s};
    end
  end

  // status pin shows the top stage after each rising clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_q <= 1'b0;
    end else if (!por_ok || cs_fall) begin
      sdo_q <= 1'b0;
    end else if (sclk_rise) begin
      sdo_q <= shift_q[N-1];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= por_ok & ~cs_n_s;
    end
  end

  // a short frame still latches whatever the stages hold
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_q <= '0;
    end else if (!por_ok) begin
      cmd_q <= '0;
    end else if (cs_rise) begin
      cmd_q <= shift_q;
    end
  end

  always_comb begin
    direct_mask           = '0;
    direct_mask[FIVE_IDX] = drive5_s;
    direct_mask[SIX_IDX]  = drive6_s;
  end

  // enable low gates the drivers but keeps the latched command
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gate_q <= '0;
    end else if (!por_ok || !enable_s) begin
      gate_q <= '0;
    end else begin
      gate_q <= cmd_q | direct_mask;
    end
  end

  assign gate_drive        = gate_q;
  assign command_latched   = cmd_q;
  assign link.status_out   = sdo_q;
  assign link.status_oe    = sdo_oe_q;
endmodule

// ==== testbench/switch_link_sva.sv ====
// protocol checker for the serial link between controller and switch device
`timescale 1ns/100ps
module switch_link_sva (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_command_in,
  input wire logic status_out,
  input wire logic status_oe,
  input wire logic direct_drive_five,
  input wire logic direct_drive_six
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // device sees select through a sync, so allow a few cycles of lag
  a_oe_when_idle: assert property (cs_n [*8] |-> !status_oe)
    else $error("status driven while deselected");
  a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:8] status_oe)
    else $error("status not driven after select");
  a_sclk_at_cs: assert property ($changed(cs_n) |-> !sclk && !$past(sclk))
    else $error("serial clock high at select edge");
  a_sclk_parked: assert property (cs_n |-> !sclk)
    else $error("serial clock moves while deselected");
  a_cmd_at_fall: assert property ($fell(sclk) |-> $stable(serial_command_in))
    else $error("command bit changes at sampling edge");
  // status may only move shortly after a rising serial edge
  a_status_hold: assert property (!sclk && !$past(sclk, 5) && !$past(cs_n, 8) && !cs_n
    |-> $stable(status_out))
    else $error("status bit moved while clock low");
  a_pwm_five: assert property ($changed(direct_drive_five)
    |=> $stable(direct_drive_five) [*8])
    else $error("direct drive five toggles too fast");
  a_pwm_six: assert property ($changed(direct_drive_six)
    |=> $stable(direct_drive_six) [*8])
    else $error("direct drive six toggles too fast");
endmodule

// ==== testbench/octal_serial_switch_control_tb_top.sv ====
// testbench: controller and device joined by the link, driven over wishbone
`timescale 1ns/100ps
module octal_serial_switch_control_tb_top;
  import switch_pkg::*;
  logic        sys_clk;
  logic        arst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] dw;
  logic [31:0] dr;
  logic [31:0] rd;
  logic        ack;
  logic        irq;
  logic        chip_enable;
  logic        supply_good;
  logic [7:0]  gate_drive;
  logic [7:0]  command_latched;
  int          errors;
  int          n_compared;

  switch_link_if link_if ();

  switch_controller #(.SCLK_HALF(10), .PWM_MIN(20)) i_switch_controller (
    .sys_clk(sys_clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .irq_o(irq), .link(link_if.ctrl));

  // fault word 8'h82: open load on output eight, short on output two
  switch_device i_switch_device (
    .sys_clk(sys_clk), .arst_n(arst_n), .link(link_if.device),
    .chip_enable(chip_enable), .supply_good(supply_good),
    .open_load(8'h80), .short_load(8'h02), .gate_drive(gate_drive),
    .command_latched(command_latched));

  switch_link_sva i_switch_link_sva (
    .sys_clk(sys_clk), .arst_n(arst_n), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
    .serial_command_in(link_if.serial_command_in), .status_out(link_if.status_out),
    .status_oe(link_if.status_oe), .direct_drive_five(link_if.direct_drive_five),
    .direct_drive_six(link_if.direct_drive_six));

  always #12.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one classic cycle; read data taken at the edge that sees ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    @(posedge sys_clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 50)
      errors++;
    rd = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // dbl issues a second start while busy, which must be refused
  task automatic frame(input logic [2:0] len, input logic [31:0] tx, input logic dbl);
    int n;
    n = 0;
    bus(1'b1, ADDR_LEN, {29'h0, len});
    bus(1'b1, ADDR_TX, tx);
    bus(1'b1, ADDR_CTRL, 32'h1);
    if (dbl)
      bus(1'b1, ADDR_CTRL, 32'h1);
    rd = 32'h1;
    while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 2000) begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end
    if (n >= 2000)
      errors++;
    bus(1'b0, ADDR_RX, 32'h0);
  endtask

  task automatic t_reset();
    chk(gate_drive, 8'h00);
    chk(link_if.status_oe, 1'b0);
    chk(irq, 1'b0);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ADDR_TX, 32'h0);
    chk(rd, TX_RESET);
    bus(1'b0, ADDR_LEN, 32'h0);
    chk(rd[2:0], LEN_RESET);
    bus(1'b0, ADDR_DIRECT, 32'h0);
    chk(rd[3:0], DIRECT_RESET);
    bus(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(rd[1:0], MASK_RESET);
  endtask

  task automatic t_single();
    frame(3'h1, 32'ha5, 1'b0);
    chk(rd[7:0], 8'h82);
    chk(command_latched, 8'ha5);
    chk(gate_drive, 8'ha5);
    chk(irq, 1'b0);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[1:0], 2'h1);
  endtask

  // second byte out is the first byte in, delayed by eight stages
  task automatic t_daisy();
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    frame(3'h2, 32'h3c96, 1'b1);
    chk(rd[15:0], 16'h823c);
    chk(command_latched, 8'h96);
    chk(irq, 1'b1);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd[1:0], 2'h3);
    wt(3);
    chk(irq, 1'b0);
  endtask

  task automatic t_enable();
    chip_enable <= 1'b0;
    wt(8);
    chk(gate_drive, 8'h00);
    chip_enable <= 1'b1;
    wt(8);
    chk(gate_drive, 8'h96);
  endtask

  task automatic t_direct();
    bus(1'b1, ADDR_DIRECT, 32'h3);
    frame(3'h1, 32'hff, 1'b0);
    chk(command_latched, 8'hcf);
    chk(gate_drive, 8'hcf);
    wt(30);
    bus(1'b1, ADDR_DIRECT, 32'hf);
    wt(8);
    chk(gate_drive, 8'hff);
    wt(30);
    bus(1'b1, ADDR_DIRECT, 32'h7);
    wt(8);
    chk(gate_drive, 8'hdf);
    wt(30);
    // quick level flip on six must be paced out by the controller
    bus(1'b1, ADDR_DIRECT, 32'hf);
    bus(1'b1, ADDR_DIRECT, 32'h3);
    chk(link_if.direct_drive_six, 1'b1);
    wt(30);
    chk(link_if.direct_drive_six, 1'b0);
    // levels without pwm mode leave the direct inputs low
    bus(1'b1, ADDR_DIRECT, 32'hc);
    wt(30);
    chk(gate_drive, 8'hcf);
  endtask

  task automatic t_supply();
    supply_good <= 1'b0;
    wt(8);
    chk(gate_drive, 8'h00);
    chk(command_latched, 8'h00);
    supply_good <= 1'b1;
    wt(8);
    chk(gate_drive, 8'h00);
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dw = 32'h0;
    chip_enable = 1'b1;
    supply_good = 1'b1;
    errors = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_single();
    t_daisy();
    t_enable();
    t_direct();
    t_supply();
    give_verdict();
  end

  // whole run is about a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end
endmodule
